/* bench/etd_host_model.sv */
// Host model: the descriptor table that software lays out in memory.
// Assumes the bench selects a slot by address and owns the valid line.
`timescale 1ns/1ps
module etd_host_model (
	input  wire logic                          valid_i,
	input  wire logic [31:0]                   addr_i,
	output etd_pkg::etd_tx_desc_control_word_t ctrl_o,
	output logic      [31:0]                   buf1_o,
	output logic      [31:0]                   buf2_o
);
	import etd_pkg::*;

	etd_tx_desc_control_word_t cw_mem [16];
	logic [31:0]               b2_mem [16];

	// Software writes a slot: frame flags as the bench lays them, reserved bit zero
	task automatic put(input logic [31:0] a, input etd_tx_desc_control_word_t cw,
		input logic [31:0] b2);
		cw_mem[a[7:4]]              = cw;
		cw_mem[a[7:4]].reserved_bit = 1'b0;
		b2_mem[a[7:4]]              = b2;
	endtask : put

	// Outside a valid offer the words are inverted, so stale data never matches
	always_comb
	begin
		ctrl_o = valid_i ? cw_mem[addr_i[7:4]]
			: etd_tx_desc_control_word_t'(~cw_mem[addr_i[7:4]]);
		buf1_o = valid_i ? addr_i + 32'h0000_0100 : ~addr_i;
		buf2_o = valid_i ? b2_mem[addr_i[7:4]] : ~b2_mem[addr_i[7:4]];
	end

endmodule : etd_host_model

/* bench/tb.sv */
// Testbench: offers descriptors, drains fetch commands, reports frame ends.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/1ps
module tb;
	import etd_pkg::*;

	localparam logic [31:0] BASE = 32'h0000_1000;
	localparam logic [8:0]  F_IRQ = 9'h100;
	localparam logic [8:0]  F_LST = 9'h080;
	localparam logic [8:0]  F_FST = 9'h040;
	localparam logic [8:0]  F_FL  = 9'h0C0;
	localparam logic [8:0]  F_RG  = 9'h004;
	localparam logic [8:0]  F_CH  = 9'h002;

	logic                      clk = 1'b0;
	logic                      rst = 1'b1;
	logic                      dv  = 1'b0;
	logic                      fr  = 1'b0;
	logic                      v4  = 1'b1;
	logic                      fd  = 1'b0;
	logic [31:0]               da  = 32'h0000_1000;
	etd_tx_desc_control_word_t cw;
	logic [31:0]               b1, b2, na;
	etd_fetch_cmd_t            fc;
	logic                      dr, nv, fv, ti, crc, pad, byp, ip4, l4, psd, l6;
	int                        err_count   = 0;
	int                        checks_done = 0;

	// 100 MHz system clock
	always #5 clk = ~clk;

	etd_host_model i_host (.valid_i(dv), .addr_i(da), .ctrl_o(cw), .buf1_o(b1), .buf2_o(b2));

	etd_desc_ctrl i_dut (
		.CLK_SYS_I(clk), .RST_I(rst), .DESC_VALID_I(dv), .DESC_READY_O(dr),
		.DESC_ADDR_I(da), .CTRL_WORD_I(cw), .BUF1_ADDR_I(b1), .BUF2_ADDR_I(b2),
		.LIST_BASE_I(BASE), .NEXT_DESC_VALID_O(nv), .NEXT_DESC_ADDR_O(na),
		.FETCH_VALID_O(fv), .FETCH_READY_I(fr), .FETCH_CMD_O(fc), .IS_IPV4_I(v4),
		.FRAME_DONE_I(fd), .TX_INT_O(ti), .CRC_APPEND_O(crc), .PAD_EN_O(pad),
		.CSUM_BYPASS_O(byp), .IPV4_HDR_CSUM_O(ip4), .L4_CSUM_O(l4),
		.L4_PSEUDO_IN_O(psd), .L4_OVER_IPV6_O(l6)
	);

	// Verdict and end of run, also reached when a wait runs out
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One cycle on; inputs always move 1 ns after the edge
	task automatic tick(inout int n);
		n++;
		if (n > 60)
		begin
			err_count++;
			finish_test();
		end
		@(posedge clk);
		#1;
	endtask : tick

	task automatic offer(input logic [31:0] a);
		int n;
		n  = 0;
		da = a;
		dv = 1'b1;
		while (dr !== 1'b1) tick(n);
		tick(n);
		dv = 1'b0;
	endtask : offer

	task automatic wait_nx(input logic [31:0] exp);
		int n;
		n = 0;
		while (nv !== 1'b1) tick(n);
		chk(na, exp);
	endtask : wait_nx

	task automatic run(input logic [31:0] a, input logic [8:0] f, input logic [10:0] s2,
		input logic [10:0] s1, input logic [31:0] b2x, input logic [31:0] exp);
		i_host.put(a, {f, 1'b0, s2, s1}, b2x);
		offer(a);
		wait_nx(exp);
	endtask : run

	// Consumer takes one command; ready stays up until done or the main sequence lowers it
	task automatic take(input logic [31:0] a, input logic [10:0] s, input logic sf,
		input logic ef);
		int n;
		n  = 0;
		fr = 1'b1;
		while (fv !== 1'b1) tick(n);
		chk(fc, {a, s, sf, ef});
		tick(n);
	endtask : take

	// Frame end pulse; the interrupt is a single-cycle pulse right after it
	task automatic done(input logic e);
		int   n;
		logic s;
		n  = 0;
		fr = 1'b0;
		fd = 1'b1;
		tick(n);
		fd = 1'b0;
		s  = ti;
		tick(n);
		chk({s, ti}, {e, 1'b0});
	endtask : done

	task automatic frame1(input logic [31:0] a, input logic [8:0] f, input logic [10:0] s1,
		input logic [31:0] exp);
		run(a, f | F_FL, 11'h000, s1, 32'h0000_0000, exp);
		take(a + 32'h0000_0100, s1, 1'b1, 1'b1);
		done(f[8]);
	endtask : frame1

	// Main sequence
	initial
	begin
		logic [2:0] k;
		logic [1:0] m;
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		chk({dr, nv, fv, ti, crc, pad, byp, ip4, l4, psd, l6}, 11'h400);
		done(1'b0);
		run(BASE, F_FL, 11'h020, 11'h040, 32'h0000_3000, 32'h0000_1010);
		take(32'h0000_1100, 11'h040, 1'b1, 1'b0);
		take(32'h0000_3000, 11'h020, 1'b0, 1'b1);
		done(1'b0);
		run(32'h0000_1010, F_FL | F_CH | F_IRQ, 11'h7FF, 11'h010, 32'h0000_2037,
			32'h0000_2030);
		take(32'h0000_1110, 11'h010, 1'b1, 1'b1);
		done(1'b1);
		run(32'h0000_1020, F_FL | F_RG, 11'h020, 11'h000, 32'h0000_3000, BASE);
		take(32'h0000_3000, 11'h020, 1'b1, 1'b1);
		done(1'b0);
		frame1(32'h0000_1030, F_RG | F_CH, 11'h008, BASE);
		// Every pairing of the CRC and padding switches
		for (k = 3'h0; k < 3'h4; k++)
		begin
			frame1(BASE, {5'h00, k[1], 2'h0, k[0]}, 11'h005, 32'h0000_1010);
			chk(crc, !k[1] | !k[0]);
			chk(pad, !k[0]);
		end
		// Three-part frame: options of a later segment must not stick
		run(BASE, F_FST, 11'h000, 11'h010, 32'h0000_0000, 32'h0000_1010);
		run(32'h0000_1010, 9'h03B, 11'h000, 11'h000, 32'h0000_104C, 32'h0000_1048);
		run(32'h0000_1048, F_LST | F_IRQ, 11'h000, 11'h004, 32'h0000_0000, 32'h0000_1058);
		take(32'h0000_1100, 11'h010, 1'b1, 1'b0);
		take(32'h0000_1148, 11'h004, 1'b0, 1'b1);
		done(1'b1);
		chk({crc, pad, byp}, 3'h7);
		// All checksum modes over IPv4, and all but the header-only mode over IPv6
		for (k = 3'h0; k < 3'h2; k++)
			for (int j = 0; j < 4; j++)
			begin
				m = 2'(j);
				if (m != 2'h1 || k[0])
				begin
					v4 = k[0];
					frame1(BASE, {3'h0, m, 4'h0}, 11'h001, 32'h0000_1010);
					chk({byp, ip4, l4, psd, l6}, {m == 2'h0, k[0] && m != 2'h0, m[1],
						m == 2'h2, m[1] && !k[0]});
				end
			end
		// Fill the command queue with the consumer stalled
		for (k = 3'h0; k < 3'h4; k++)
			run(BASE + {25'h0, k, 4'h0}, (k == 3'h0) ? F_FST : 9'h000, 11'h001, 11'h001,
				32'h0000_3000, BASE + {25'h0, k + 3'h1, 4'h0});
		i_host.put(32'h0000_1040, {F_LST, 1'b0, 11'h001, 11'h001}, 32'h0000_3000);
		offer(32'h0000_1040);
		repeat (6)
		begin
			chk(nv, 1'b0);
			@(posedge clk);
			#1;
		end
		take(32'h0000_1100, 11'h001, 1'b1, 1'b0);
		take(32'h0000_3000, 11'h001, 1'b0, 1'b0);
		fr = 1'b0;
		wait_nx(32'h0000_1050);
		for (k = 3'h1; k < 3'h5; k++)
		begin
			take(BASE + {25'h0, k, 4'h0} + 32'h0000_0100, 11'h001, 1'b0, 1'b0);
			take(32'h0000_3000, 11'h001, 1'b0, k == 3'h4);
		end
		done(1'b0);
		finish_test();
	end

endmodule : tb

/* design/etd_desc_ctrl.sv */
// Transmit descriptor control word decoder and buffer sequencer.
// Assumes descriptor words arrive already fetched, on CLK_SYS_I, and
// that the data mover drains fetch commands and reports frame ends.
`timescale 1ns/1ps
module etd_desc_ctrl #(
	parameter int          FIFO_DEPTH  = etd_pkg::FIFO_DEPTH_DEF,
	parameter logic [31:0] DESC_STRIDE = etd_pkg::DESC_STRIDE_DEF,
	parameter int          BUS_BYTES   = etd_pkg::BUS_BYTES_DEF
) (
	input  wire logic                               CLK_SYS_I,
	input  wire logic                               RST_I,
	input  wire logic                               DESC_VALID_I,
	output logic                                    DESC_READY_O,
	input  wire logic [31:0]                        DESC_ADDR_I,
	input  wire etd_pkg::etd_tx_desc_control_word_t CTRL_WORD_I,
	input  wire logic [31:0]                        BUF1_ADDR_I,
	input  wire logic [31:0]                        BUF2_ADDR_I,
	input  wire logic [31:0]                        LIST_BASE_I,
	output logic                                    NEXT_DESC_VALID_O,
	output logic      [31:0]                        NEXT_DESC_ADDR_O,
	output logic                                    FETCH_VALID_O,
	input  wire logic                               FETCH_READY_I,
	output etd_pkg::etd_fetch_cmd_t                 FETCH_CMD_O,
	input  wire logic                               IS_IPV4_I,
	input  wire logic                               FRAME_DONE_I,
	output logic                                    TX_INT_O,
	output logic                                    CRC_APPEND_O,
	output logic                                    PAD_EN_O,
	output logic                                    CSUM_BYPASS_O,
	output logic                                    IPV4_HDR_CSUM_O,
	output logic                                    L4_CSUM_O,
	output logic                                    L4_PSEUDO_IN_O,
	output logic                                    L4_OVER_IPV6_O
);
	import etd_pkg::*;

	localparam logic [31:0] ALIGN_MASK = ~(32'(BUS_BYTES) - 32'h0000_0001);
	localparam int          CQ_AW      = $clog2(CQ_DEPTH);

	typedef struct packed {
		etd_state_e_t              fsm;
		etd_tx_desc_control_word_t word;
		logic [31:0]               buf1_addr;
		logic [31:0]               buf2_addr;
		logic [31:0]               cur_addr;
		logic [31:0]               next_addr;
		logic                      next_valid;
		logic                      crc_append;
		logic                      pad_en;
		logic [1:0]                csum_mode;
		logic                      csum_bypass;
		logic                      ip_hdr;
		logic                      l4;
		logic                      l4_pseudo;
		logic                      l4_v6;
		logic [CQ_DEPTH-1:0]       cq_irq;
		logic [3:0]                cq_cnt;
		logic                      tx_int;
	} etd_state_t;

	etd_state_t     st_r;
	etd_state_t     st_nxt;
	etd_fetch_cmd_t cmd;
	logic           push;
	logic           push_ok;
	logic           fifo_ready;
	logic           take;
	logic           b1_skip;
	logic           b2_use;
	logic           pop_done;
	logic           push_eof;
	logic [3:0]     cnt_after_pop;

	// A zero size skips buffer one; chaining hides buffer two entirely
	assign b1_skip = (st_r.word.buffer_one_size == SIZE_ZERO);
	assign b2_use  = !st_r.word.chained_next_desc &&
		(st_r.word.buffer_two_size != SIZE_ZERO);

	assign DESC_READY_O = (st_r.fsm == ST_IDLE);
	assign take         = DESC_VALID_I && DESC_READY_O;

	// Build the fetch command for whichever buffer is current
	always_comb
	begin
		cmd  = '0;
		push = 1'b0;
		if (st_r.fsm == ST_BUF1 && !b1_skip)
		begin
			cmd.addr = st_r.buf1_addr;
			cmd.size = st_r.word.buffer_one_size;
			cmd.sof  = st_r.word.first_segment_flag;
			cmd.eof  = st_r.word.last_segment_flag && !b2_use;
			push     = 1'b1;
		end
		else if (st_r.fsm == ST_BUF2 && b2_use)
		begin
			cmd.addr = st_r.buf2_addr;
			cmd.size = st_r.word.buffer_two_size;
			cmd.sof  = st_r.word.first_segment_flag && b1_skip;
			cmd.eof  = st_r.word.last_segment_flag;
			push     = 1'b1;
		end
	end

	// A frame end needs a completion slot, so a full queue stalls it
	assign push_eof = push && cmd.eof;
	assign push_ok  = push && fifo_ready && !(push_eof && st_r.cq_cnt == CQ_CNT_FULL);
	assign pop_done = FRAME_DONE_I && (st_r.cq_cnt != CQ_CNT_ZERO);
	assign cnt_after_pop = pop_done ? st_r.cq_cnt - CQ_CNT_ONE : st_r.cq_cnt;

	// Sequencer, frame configuration and completion queue
	always_comb
	begin
		st_nxt            = st_r;
		st_nxt.next_valid = 1'b0;
		st_nxt.tx_int     = 1'b0;
		unique case (st_r.fsm)
			ST_IDLE:
			begin
				if (take)
				begin
					// Reserved bit rides along in the word; nothing decodes it
					st_nxt.word      = CTRL_WORD_I;
					st_nxt.buf1_addr = BUF1_ADDR_I;
					st_nxt.buf2_addr = BUF2_ADDR_I;
					st_nxt.cur_addr  = DESC_ADDR_I;
					st_nxt.fsm       = ST_BUF1;
					// Frame options only taken from a first segment
					if (CTRL_WORD_I.first_segment_flag)
					begin
						st_nxt.pad_en     = !CTRL_WORD_I.no_pad_flag;
						st_nxt.crc_append = !CTRL_WORD_I.no_crc_append ||
							!CTRL_WORD_I.no_pad_flag;
						st_nxt.csum_mode  = CTRL_WORD_I.checksum_insert_ctrl;
					end
				end
			end
			ST_BUF1:
			begin
				if (b1_skip || push_ok)
					st_nxt.fsm = ST_BUF2;
			end
			ST_BUF2:
			begin
				if (!b2_use || push_ok)
					st_nxt.fsm = ST_NEXT;
			end
			ST_NEXT:
			begin
				// Ring end first, then chain pointer, else contiguous list
				if (st_r.word.ring_end_flag)
					st_nxt.next_addr = LIST_BASE_I;
				else if (st_r.word.chained_next_desc)
					st_nxt.next_addr = st_r.buf2_addr & ALIGN_MASK;
				else
					st_nxt.next_addr = st_r.cur_addr + DESC_STRIDE;
				st_nxt.next_valid = 1'b1;
				st_nxt.fsm        = ST_IDLE;
			end
		endcase

		// Checksum controls follow the latched mode and the parser's version
		st_nxt.csum_bypass = (st_nxt.csum_mode == CSUM_BYPASS);
		st_nxt.ip_hdr      = (st_nxt.csum_mode != CSUM_BYPASS) && IS_IPV4_I;
		st_nxt.l4          = (st_nxt.csum_mode == CSUM_L4_SEG) ||
			(st_nxt.csum_mode == CSUM_L4_FULL);
		st_nxt.l4_pseudo   = (st_nxt.csum_mode == CSUM_L4_SEG);
		st_nxt.l4_v6       = st_nxt.l4 && !IS_IPV4_I;

		// In-order completion queue: shift out on done, append on frame end
		if (pop_done)
		begin
			st_nxt.tx_int = st_r.cq_irq[0];
			st_nxt.cq_irq = {1'b0, st_r.cq_irq[CQ_DEPTH-1:1]};
		end
		if (push_ok && push_eof)
		begin
			st_nxt.cq_irq[cnt_after_pop[CQ_AW-1:0]] =
				st_r.word.interrupt_on_completion;
			st_nxt.cq_cnt = cnt_after_pop + CQ_CNT_ONE;
		end
		else
			st_nxt.cq_cnt = cnt_after_pop;
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			st_r     <= '0;
			st_r.fsm <= ST_IDLE;
		end
		else
			st_r <= st_nxt;
	end

	// Commands buffered so descriptor decode runs ahead of the data mover
	etd_fifo #(
		.WIDTH (FETCH_CMD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CLK_SYS_I),
		.rst_i       (RST_I),
		.in_valid_i  (push_ok),
		.in_ready_o  (fifo_ready),
		.in_data_i   (cmd),
		.out_valid_o (FETCH_VALID_O),
		.out_ready_i (FETCH_READY_I),
		.out_data_o  (FETCH_CMD_O)
	);

	// Registered outputs
	assign NEXT_DESC_VALID_O = st_r.next_valid;
	assign NEXT_DESC_ADDR_O  = st_r.next_addr;
	assign TX_INT_O          = st_r.tx_int;
	assign CRC_APPEND_O      = st_r.crc_append;
	assign PAD_EN_O          = st_r.pad_en;
	assign CSUM_BYPASS_O     = st_r.csum_bypass;
	assign IPV4_HDR_CSUM_O   = st_r.ip_hdr;
	assign L4_CSUM_O         = st_r.l4;
	assign L4_PSEUDO_IN_O    = st_r.l4_pseudo;
	assign L4_OVER_IPV6_O    = st_r.l4_v6;

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	// Interrupt only follows a real completion
	chk_int_after_done: assert property (TX_INT_O |-> $past(pop_done))
		else $error("interrupt without frame completion");
	// Ring end wins: next address is the base
	chk_ring_end_base: assert property (
		(st_r.fsm == ST_NEXT && st_r.word.ring_end_flag)
		|=> NEXT_DESC_VALID_O && NEXT_DESC_ADDR_O == $past(LIST_BASE_I))
		else $error("ring end did not return to list base");
	// Chained pointer is aligned to the bus width
	chk_chain_align: assert property (
		(st_r.fsm == ST_NEXT && !st_r.word.ring_end_flag && st_r.word.chained_next_desc)
		|=> NEXT_DESC_ADDR_O == ($past(st_r.buf2_addr) & ALIGN_MASK))
		else $error("chained next address wrong");
	// Without ring end or chaining the next descriptor follows in memory
	chk_contig_next: assert property (
		(st_r.fsm == ST_NEXT && !st_r.word.ring_end_flag && !st_r.word.chained_next_desc)
		|=> NEXT_DESC_ADDR_O == $past(st_r.cur_addr) + DESC_STRIDE)
		else $error("contiguous next address wrong");
	// Chained descriptors never issue a second buffer
	chk_no_buf2_chain: assert property (
		(push_ok && st_r.fsm == ST_BUF2) |-> !st_r.word.chained_next_desc)
		else $error("buffer two fetched in chained descriptor");
	// Zero-size buffer one is never requested
	chk_skip_zero: assert property (
		push_ok |-> cmd.size != SIZE_ZERO)
		else $error("zero size fetch issued");
	// Padding enabled always appends CRC
	chk_pad_crc: assert property (PAD_EN_O |-> CRC_APPEND_O)
		else $error("padding without CRC");
	// First-segment options land the cycle after the take
	chk_crc_latch: assert property (
		(take && CTRL_WORD_I.first_segment_flag)
		|=> CRC_APPEND_O == (!$past(CTRL_WORD_I.no_crc_append) ||
			!$past(CTRL_WORD_I.no_pad_flag)))
		else $error("CRC append not taken from first segment");
	chk_pad_latch: assert property (
		(take && CTRL_WORD_I.first_segment_flag)
		|=> PAD_EN_O == !$past(CTRL_WORD_I.no_pad_flag))
		else $error("padding not taken from first segment");
	// Non-first segments leave frame options untouched
	chk_opts_first: assert property (
		(take && !CTRL_WORD_I.first_segment_flag)
		|=> $stable(CRC_APPEND_O) && $stable(PAD_EN_O))
		else $error("frame options changed by non-first segment");
	// Bypass mode drives no insertion at all
	chk_bypass_quiet: assert property (
		CSUM_BYPASS_O |-> !IPV4_HDR_CSUM_O && !L4_CSUM_O)
		else $error("checksum inserted in bypass mode");
	// Pseudo-header sum only matters when a transport checksum is inserted
	chk_pseudo_l4: assert property (L4_PSEUDO_IN_O |-> L4_CSUM_O)
		else $error("pseudo-header flag without transport checksum");
	// An IPv6 segment never gets an IPv4 header checksum
	chk_v6_no_hdr: assert property (L4_OVER_IPV6_O |-> !IPV4_HDR_CSUM_O)
		else $error("IPv4 header checksum on IPv6 segment");
	// With room for both buffers the next address is posted four cycles after the take
	chk_desc_finish: assert property (
		take ##1 (fifo_ready && st_r.cq_cnt != CQ_CNT_FULL) [*2]
		|-> ##2 NEXT_DESC_VALID_O)
		else $error("descriptor sequencing stalled");

endmodule : etd_desc_ctrl

/* design/etd_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; write and read may happen in one cycle.
`timescale 1ns/1ps
module etd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0]   count;
	} etd_fifo_state_t;

	logic [WIDTH-1:0] mem [DEPTH];
	etd_fifo_state_t  st_r;
	etd_fifo_state_t  st_nxt;
	logic             do_wr;
	logic             do_rd;

	// Full and empty come straight from the occupancy count
	assign in_ready_o  = (st_r.count != (AW+1)'(DEPTH));
	assign out_valid_o = (st_r.count != '0);
	assign out_data_o  = mem[st_r.rptr];
	assign do_wr       = in_valid_i && in_ready_o;
	assign do_rd       = out_valid_o && out_ready_i;

	// Pointer wrap handled explicitly so non power of two depths work
	always_comb
	begin
		st_nxt = st_r;
		if (do_wr)
			st_nxt.wptr = (st_r.wptr == AW'(DEPTH-1)) ? '0 : st_r.wptr + AW'(1);
		if (do_rd)
			st_nxt.rptr = (st_r.rptr == AW'(DEPTH-1)) ? '0 : st_r.rptr + AW'(1);
		if (do_wr && !do_rd)
			st_nxt.count = st_r.count + (AW+1)'(1);
		else if (do_rd && !do_wr)
			st_nxt.count = st_r.count - (AW+1)'(1);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Storage has no reset; only entries below count are ever read
	always_ff @(posedge clk_i)
	begin
		if (do_wr)
			mem[st_r.wptr] <= in_data_i;
	end

endmodule : etd_fifo

/* inc/etd_pkg.sv */
// Package for the transmit descriptor control word decoder.
// Assumes one system clock domain; all users import etd_pkg::*.
package etd_pkg;

	// Second descriptor word as software writes it
	typedef struct packed {
		logic        interrupt_on_completion;
		logic        last_segment_flag;
		logic        first_segment_flag;
		logic [1:0]  checksum_insert_ctrl;
		logic        no_crc_append;
		logic        ring_end_flag;
		logic        chained_next_desc;
		logic        no_pad_flag;
		logic        reserved_bit;        // Carried but never read
		logic [10:0] buffer_two_size;
		logic [10:0] buffer_one_size;
	} etd_tx_desc_control_word_t;

	// One buffer fetch request handed to the data mover
	typedef struct packed {
		logic [31:0] addr;
		logic [10:0] size;
		logic        sof;
		logic        eof;
	} etd_fetch_cmd_t;

	localparam int FETCH_CMD_W = $bits(etd_fetch_cmd_t);

	// Checksum insertion encodings
	localparam logic [1:0] CSUM_BYPASS  = 2'h0;
	localparam logic [1:0] CSUM_IPHDR   = 2'h1;
	localparam logic [1:0] CSUM_L4_SEG  = 2'h2;
	localparam logic [1:0] CSUM_L4_FULL = 2'h3;

	localparam logic [10:0] SIZE_ZERO   = 11'h000;
	localparam logic [31:0] ADDR_ZERO   = 32'h0000_0000;

	// Defaults for sizing parameters
	localparam int          FIFO_DEPTH_DEF  = 8;
	localparam logic [31:0] DESC_STRIDE_DEF = 32'h0000_0010;
	localparam int          BUS_BYTES_DEF   = 8;
	localparam int          CQ_DEPTH        = 8;
	localparam logic [3:0]  CQ_CNT_FULL     = 4'h8;
	localparam logic [3:0]  CQ_CNT_ZERO     = 4'h0;
	localparam logic [3:0]  CQ_CNT_ONE      = 4'h1;

	// Sequencer states, Gray coded along idle, buf1, buf2, next
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BUF1 = 2'h1,
		ST_BUF2 = 2'h3,
		ST_NEXT = 2'h2
	} etd_state_e_t;

endpackage : etd_pkg
